//--- shared/tmh_cfg.svh
`ifndef TMH_CFG_SVH
`define TMH_CFG_SVH

// Mode field layout
`define TMH_MODE_W 5
`define TMH_MODE_HI_MSB 4
`define TMH_MODE_HI_LSB 3
`define TMH_MODE_LO_MSB 2
`define TMH_MODE_LO_LSB 0

// Upper mode bits
`define TMH_HI_FREE 2'h0
`define TMH_HI_ONESHOT 2'h1
`define TMH_HI_MONO 2'h2
`define TMH_HI_RSVD 2'h3

// Lower mode bits
`define TMH_LO_SOFT 3'h0
`define TMH_LO_RISE 3'h1
`define TMH_LO_FALL 3'h2
`define TMH_LO_ANY 3'h3
`define TMH_LO_RISE_RST 3'h4
`define TMH_LO_FALL_RST 3'h5
`define TMH_LO_HIGH 3'h6
`define TMH_LO_LOW 3'h7

// Reset values and widths
`define TMH_COUNT_W 8
`define TMH_ON_RESET 1'h0
`define TMH_RUN_RESET 1'h0

`endif

//--- shared/tmh_pkg.sv
package tmh_pkg;

    typedef enum logic [2:0] {
        TMH_CLS_IDLE = 3'b000,
        TMH_CLS_SOFT = 3'b001,
        TMH_CLS_EDGE = 3'b010,
        TMH_CLS_EDGE_RST = 3'b011,
        TMH_CLS_EDGE_LVL = 3'b100,
        TMH_CLS_MONO = 3'b101,
        TMH_CLS_LEVEL = 3'b110
    } tmh_class_t;

endpackage : tmh_pkg

//--- hw/tmh_edge_detect.sv
module tmh_edge_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Sampled level
    input wire logic level_in,
    // Edge strobes
    output logic rise,
    output logic fall
);

    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level_in;
    end

    // Follows the pin through reset, so no false edge appears at release
    always_ff @(posedge clk) begin
        if (reset) begin
            prev_q <= level_in;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign rise = level_in & ~prev_q;
    assign fall = ~level_in & prev_q;

endmodule : tmh_edge_detect

//--- hw/tmh_timer_ctrl.sv
// Function
// - Mode 01_000 starts on run bit alone
// - Mode 01_001 starts on run plus rising edge
// - Mode 01_100 rising start, later rising resets
// - Mode 01_101 falling start, later falling resets
// - Mode 01_110 rising start, low level holds reset
// - Mode 01_111 falling start, high level holds reset
// - One-shot match: next clock clears run, zero
// - Monostable 001/010/011: rise, fall, any edge start
// - Monostable 001/010/011 match: stop at zero, keep run; 110/111 clear run
// - Mode 10_110 high starts, low resets
// - Mode 10_111 low starts, high resets
// - Edge while run clear never starts counting
`include "tmh_cfg.svh"

module tmh_timer_ctrl #(
    parameter int COUNT_W = `TMH_COUNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Software control
    input wire logic [`TMH_MODE_W-1:0] mode,
    input wire logic run_set,
    input wire logic run_clr,
    input wire logic [COUNT_W-1:0] period_value,
    // External trigger
    input wire logic external_trigger_reset_input,
    // Timer state
    output logic run_on,
    output logic counting,
    output logic [COUNT_W-1:0] count_value,
    output logic period_match
);

    if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_count_w
        $error("tmh_timer_ctrl: COUNT_W must lie in 2..32");
    end

    function automatic tmh_pkg::tmh_class_t mode_class(
        input logic [`TMH_MODE_W-1:0] m
    );
        logic [1:0] hi;
        logic [2:0] lo;
        hi = m[`TMH_MODE_HI_MSB:`TMH_MODE_HI_LSB];
        lo = m[`TMH_MODE_LO_MSB:`TMH_MODE_LO_LSB];
        mode_class = tmh_pkg::TMH_CLS_IDLE;
        if (hi == `TMH_HI_ONESHOT) begin
            unique case (lo)
                `TMH_LO_SOFT: mode_class = tmh_pkg::TMH_CLS_SOFT;
                `TMH_LO_RISE, `TMH_LO_FALL, `TMH_LO_ANY: mode_class = tmh_pkg::TMH_CLS_EDGE;
                `TMH_LO_RISE_RST, `TMH_LO_FALL_RST: mode_class = tmh_pkg::TMH_CLS_EDGE_RST;
                `TMH_LO_HIGH, `TMH_LO_LOW: mode_class = tmh_pkg::TMH_CLS_EDGE_LVL;
            endcase
        end else if (hi == `TMH_HI_MONO) begin
            unique case (lo)
                `TMH_LO_RISE, `TMH_LO_FALL, `TMH_LO_ANY: mode_class = tmh_pkg::TMH_CLS_MONO;
                `TMH_LO_HIGH, `TMH_LO_LOW: mode_class = tmh_pkg::TMH_CLS_LEVEL;
                // Monostable 000 is reserved as well
                default: mode_class = tmh_pkg::TMH_CLS_IDLE;
            endcase
        end
    endfunction : mode_class

    // Edge chosen by the lower mode bits
    function automatic logic start_edge(
        input logic [2:0] lo,
        input logic rise_in,
        input logic fall_in
    );
        unique case (lo)
            `TMH_LO_RISE, `TMH_LO_RISE_RST, `TMH_LO_HIGH: start_edge = rise_in;
            `TMH_LO_FALL, `TMH_LO_FALL_RST, `TMH_LO_LOW: start_edge = fall_in;
            `TMH_LO_ANY: start_edge = rise_in | fall_in;
            `TMH_LO_SOFT: start_edge = 1'h0;
        endcase
    endfunction : start_edge

    logic ers;
    logic ers_rise;
    logic ers_fall;
    logic [2:0] lo_bits;
    tmh_pkg::tmh_class_t cls;
    logic start_ev;
    logic reset_ev;
    logic hold_rst;
    logic at_period;
    logic oneshot;

    logic on_q;
    logic on_d;
    logic running_q;
    logic running_d;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic match_q;
    logic match_d;

    assign ers = external_trigger_reset_input;
    assign lo_bits = mode[`TMH_MODE_LO_MSB:`TMH_MODE_LO_LSB];
    assign cls = mode_class(mode);
    assign at_period = (count_q == period_value);
    assign oneshot = (cls == tmh_pkg::TMH_CLS_SOFT) || (cls == tmh_pkg::TMH_CLS_EDGE)
        || (cls == tmh_pkg::TMH_CLS_EDGE_RST) || (cls == tmh_pkg::TMH_CLS_EDGE_LVL)
        || (cls == tmh_pkg::TMH_CLS_LEVEL);

    tmh_edge_detect u_edge (
        .clk(clk),
        .reset(reset),
        .level_in(ers),
        .rise(ers_rise),
        .fall(ers_fall)
    );

    // Start, reset and hold-in-reset decode per mode class
    always_comb begin
        start_ev = 1'h0;
        reset_ev = 1'h0;
        hold_rst = 1'h0;
        unique case (cls)
            tmh_pkg::TMH_CLS_IDLE: begin
                hold_rst = 1'h1;
            end
            tmh_pkg::TMH_CLS_SOFT: begin
                start_ev = 1'h1;
            end
            tmh_pkg::TMH_CLS_EDGE: begin
                start_ev = start_edge(lo_bits, ers_rise, ers_fall);
            end
            tmh_pkg::TMH_CLS_EDGE_RST: begin
                start_ev = start_edge(lo_bits, ers_rise, ers_fall);
                reset_ev = start_ev;
            end
            tmh_pkg::TMH_CLS_EDGE_LVL: begin
                start_ev = start_edge(lo_bits, ers_rise, ers_fall);
                hold_rst = (lo_bits == `TMH_LO_HIGH) ? ~ers : ers;
            end
            tmh_pkg::TMH_CLS_MONO: begin
                start_ev = start_edge(lo_bits, ers_rise, ers_fall);
            end
            tmh_pkg::TMH_CLS_LEVEL: begin
                start_ev = (lo_bits == `TMH_LO_HIGH) ? ers : ~ers;
                hold_rst = ~start_ev;
            end
        endcase
    end

    // Run bit, running flag, counter and match strobe
    always_comb begin
        on_d = on_q;
        running_d = running_q;
        count_d = count_q;
        match_d = 1'h0;
        if (run_clr) begin
            on_d = 1'h0;
        end
        // Start is judged on the registered run bit, so an edge seen while
        // the bit was clear is gone by the time the bit reads as set
        if (!on_q || hold_rst) begin
            running_d = 1'h0;
            count_d = '0;
        end else if (running_q) begin
            if (at_period) begin
                count_d = '0;
                running_d = 1'h0;
                match_d = 1'h1;
                if (oneshot) begin
                    on_d = 1'h0;
                end
            end else if (reset_ev) begin
                count_d = '0;
            end else begin
                count_d = count_q + COUNT_W'(1);
            end
        end else if (start_ev) begin
            running_d = 1'h1;
        end
        // Software set wins over the hardware clear
        if (run_set) begin
            on_d = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            on_q <= `TMH_ON_RESET;
            running_q <= `TMH_RUN_RESET;
            count_q <= '0;
            match_q <= 1'h0;
        end else begin
            on_q <= on_d;
            running_q <= running_d;
            count_q <= count_d;
            match_q <= match_d;
        end
    end

    assign run_on = on_q;
    assign counting = running_q;
    assign count_value = count_q;
    assign period_match = match_q;

    a_oneshot_clear:
    assert property (@(posedge clk) disable iff (reset)
        (on_q && running_q && at_period && oneshot && !hold_rst && !run_set)
        |=> (count_q == '0) && !on_q && !running_q && match_q)
    else $error("one-shot match did not clear run and counter");

    a_mono_keep_run:
    assert property (@(posedge clk) disable iff (reset)
        (on_q && running_q && at_period && cls == tmh_pkg::TMH_CLS_MONO && !run_clr)
        |=> (count_q == '0) && on_q && !running_q)
    else $error("monostable match lost run bit or counter");

    a_off_no_count:
    assert property (@(posedge clk) disable iff (reset)
        !on_q |=> !running_q && (count_q == '0))
    else $error("timer ran while run bit was clear");

    a_soft_start:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h08 && on_q && !running_q && !run_clr) |=> running_q)
    else $error("software start did not begin counting");

    a_rise_start:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h09 && on_q && !running_q && !ers)
        ##1 (mode == 5'h09 && on_q && ers && !run_clr) |=> running_q)
    else $error("rising edge start missed");

    a_edge_reset:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h0C && on_q && running_q && !at_period && ers_rise)
        |=> running_q && (count_q == '0))
    else $error("rising edge did not reset counter");

    a_low_hold:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h0E && !ers) |=> !running_q && (count_q == '0))
    else $error("low level did not hold counter in reset");

    a_any_edge:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h0B && on_q && !running_q && (ers_rise || ers_fall) && !run_clr)
        |=> running_q)
    else $error("any-edge start missed");

    a_level_start:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h16 && on_q && !running_q && ers && !run_clr) |=> running_q)
    else $error("high level did not start counting");

    a_reserved_idle:
    assert property (@(posedge clk) disable iff (reset)
        (mode[4:3] == 2'h3 || mode == 5'h10 || mode == 5'h14 || mode == 5'h15)
        |=> !running_q && (count_q == '0))
    else $error("reserved mode left the counter active");

    a_no_edge_idle:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h09 && on_q && !running_q && !ers_rise) |=> !running_q)
    else $error("rising edge mode started without an edge");

    a_fall_reset:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h0D && on_q && running_q && !at_period && ers_fall)
        |=> running_q && (count_q == '0))
    else $error("falling edge did not reset counter");

    a_fall_start:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h0D && on_q && !running_q && ers_fall) |=> running_q)
    else $error("falling edge start missed");

    a_high_hold:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h0F && ers) |=> !running_q && (count_q == '0))
    else $error("high level did not hold counter in reset");

    a_mono_fall:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h12 && on_q && !running_q && ers_fall) |=> running_q)
    else $error("monostable falling edge start missed");

    a_level_reset:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h16 && !ers) |=> !running_q && (count_q == '0))
    else $error("low level did not reset level-start counter");

    a_low_start:
    assert property (@(posedge clk) disable iff (reset)
        (mode == 5'h17 && on_q && !running_q && !ers) |=> running_q)
    else $error("low level did not start counting");

    a_match_pulse:
    assert property (@(posedge clk) disable iff (reset)
        match_q |=> !match_q)
    else $error("period match pulse lasted more than one cycle");

endmodule : tmh_timer_ctrl

//--- bench/tmh_trig_src.sv
module tmh_trig_src (
    // Clock
    input wire logic clk,
    // Trigger pin
    output logic trig
);
    timeunit 1ns;
    timeprecision 100ps;
    initial trig = 1'b0;
    // Moves only just after an edge, as a source synchronous to clk would
    task automatic drive(input logic lvl);
        @(posedge clk);
        #1 trig = lvl;
    endtask : drive
endmodule : tmh_trig_src

//--- bench/tb_timer_hw_limit_oneshot_modes.sv
`include "tmh_cfg.svh"
module tb_timer_hw_limit_oneshot_modes;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int cyc; logic ro;} tmh_note_t;
    // Active trigger level per lower mode bits
    localparam logic [7:0] act_tbl = 8'h5A;
    // Reserved and out-of-block mode codes, five bits each
    localparam logic [39:0] rsv_tbl = 40'hFEF15A40E0;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [`TMH_MODE_W-1:0] mode = 5'h00;
    logic run_set = 1'b0;
    logic run_clr = 1'b0;
    logic [7:0] period_value = 8'h08;
    logic ext;
    logic run_on;
    logic counting;
    logic period_match;
    logic [7:0] count_value;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int p = 8;
    integer seed = 32'hBEF2B4BF;
    tmh_note_t notes[$];
    tmh_note_t n;

    tmh_timer_ctrl #(.COUNT_W(8)) i_tmh_timer_ctrl (
        .clk(clk),
        .reset(reset),
        .mode(mode),
        .run_set(run_set),
        .run_clr(run_clr),
        .period_value(period_value),
        .external_trigger_reset_input(ext),
        .run_on(run_on),
        .counting(counting),
        .count_value(count_value),
        .period_match(period_match)
    );

    tmh_trig_src u_src (
        .clk(clk),
        .trig(ext)
    );

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic go(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : go

    task automatic push(input int c, input logic ro);
        notes.push_back('{c, ro});
    endtask : push

    // Clear run first so a monostable cannot fire on the mode change
    task automatic prep(input logic [4:0] m, input logic idle, input int pv);
        go(1);
        run_clr = 1'b1;
        go(1);
        run_clr = 1'b0;
        mode = m;
        p = pv;
        period_value = pv[7:0];
        u_src.drive(idle);
        go(3);
        run_set = 1'b1;
        go(1);
        run_set = 1'b0;
        go(3);
    endtask : prep

    task automatic start(input logic [4:0] m, input logic act, input logic ro);
        prep(m, ~act, 1 + {$random(seed)} % 12);
        u_src.drive(act);
        push(cyc + p + 2, ro);
        go(p + 6);
        if (ro && m[2:0] != 3'h3) begin
            u_src.drive(~act);
            go(2);
            u_src.drive(act);
            push(cyc + p + 2, ro);
            go(p + 6);
        end
    endtask : start

    task automatic retrig(input logic [4:0] m, input logic act, input logic mid);
        prep(m, ~act, 8);
        u_src.drive(act);
        go(2);
        u_src.drive(~act);
        go(2);
        check("counting", counting, mid);
        check("count_value", count_value, mid ? 4 : 0);
        u_src.drive(act);
        push(cyc + p + 2, 1'b0);
        go(p + 6);
    endtask : retrig

    // Each match pulse must line up with the oldest note
    always @(negedge clk) begin
        if (period_match === 1'b1) begin
            if (notes.size() == 0) begin
                check("extra_match", 1, 0);
            end else begin
                n = notes.pop_front();
                check("match_cycle", cyc, n.cyc);
                check("run_on", run_on, n.ro);
                check("count_value", count_value, 0);
            end
        end
    end

    initial begin
        #40000;
        num_errors++;
        results();
    end

    initial begin
        go(16);
        reset = 1'b0;
        go(1);
        mode = {`TMH_HI_ONESHOT, `TMH_LO_SOFT};
        go(1);
        run_set = 1'b1;
        push(cyc + p + 3, 1'b0);
        go(1);
        run_set = 1'b0;
        go(p + 6);
        prep({`TMH_HI_ONESHOT, `TMH_LO_RISE}, 1'b0, 4);
        run_clr = 1'b1;
        go(1);
        run_clr = 1'b0;
        u_src.drive(1'b0);
        u_src.drive(1'b1);
        go(2);
        run_set = 1'b1;
        go(1);
        run_set = 1'b0;
        go(4);
        check("counting", counting, 0);
        for (int lo = 1; lo < 8; lo++) begin
            start({`TMH_HI_ONESHOT, lo[2:0]}, act_tbl[lo], 1'b0);
        end
        for (int lo = 1; lo < 8; lo++) begin
            if (lo < 4 || lo > 5) start({`TMH_HI_MONO, lo[2:0]}, act_tbl[lo], lo < 4);
        end
        for (int lo = 4; lo < 8; lo++) begin
            retrig({`TMH_HI_ONESHOT, lo[2:0]}, act_tbl[lo], lo < 6);
        end
        // Reserved and out-of-block modes must never leave idle
        for (int i = 0; i < 8; i++) begin
            prep(rsv_tbl[i*5 +: 5], 1'b0, 4);
            u_src.drive(1'b1);
            u_src.drive(1'b0);
            go(3);
            check("counting", counting, 0);
            check("count_value", count_value, 0);
        end
        go(4);
        check("pending", notes.size(), 0);
        results();
    end
endmodule : tb_timer_hw_limit_oneshot_modes
